// File: closed_loop_axis_trigger_control.sv
`timescale 1ns/1ns
// Overview of operation
// - only falling trigger edges request a command
// - on trigger sample inputs, execute function
// - run trigger starts motion, halt trigger stops
// - step input at one selects step mode
// - new target is position plus signed step
// - early steps accumulate onto pending target
// - direction chooses adding or subtracting step
// - halt mid-step holds present position
// - later steps start from held position
// - steps toward a limit still accumulate
// - position error sticky until counter reset
// - stall removes drive, error until next command or counter reset
// - low battery raises persistent error
// - checksum failure raises persistent error
// - host code 0 executes motor operation
// - host code 1 zeroes counter and target
// - output-control shows data port direction
// - three axes per chassis, fifteen addresses
// - ignore triggers when port off or unsupervised
// - outside step mode only maintenance regulates
module closed_loop_axis_trigger_control
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_port_off,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_trigger,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_step_mode,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_dir_fwd,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_halt,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_speed_clk,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_enc_inc,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_enc_dec,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_fwd_limit,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_rev_limit,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_pos_err_evt,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_stall_evt,
  input wire logic i_low_batt,
  input wire logic i_sum_fail,
  output logic [axis_ctl_pkg::NUM_AXES-1:0] o_supervisor_present_short_n,
  output logic [axis_ctl_pkg::NUM_AXES-1:0] o_drive_en,
  output logic [axis_ctl_pkg::NUM_AXES-1:0] o_drive_fwd,
  output logic [axis_ctl_pkg::NUM_AXES-1:0] o_drive_clk,
  output logic o_out_ctrl,
  output logic o_rom_err,
  output logic o_batt_err
);
  import axis_ctl_pkg::*;

  localparam int NA = NUM_AXES;

  logic [7:0] ctrl_q;
  logic [POS_W-1:0] step_q [NA];
  logic [POS_W-1:0] pos_q [NA];
  logic [POS_W-1:0] tgt_q [NA];
  logic [POS_W-1:0] delta [NA];
  logic [POS_W-1:0] base [NA];
  axis_state_t state_q [NA];
  logic [NA-1:0] run_fwd_q;
  logic [NA-1:0] pos_err_q;
  logic [NA-1:0] stall_err_q;
  logic [NA-1:0] drive_en_q;
  logic [NA-1:0] drive_fwd_q;
  logic [NA-1:0] drive_clk_q;
  logic [NA-1:0] sup_n_q;
  logic [NA-1:0] en_d;
  logic [NA-1:0] fwd_d;
  logic [NA-1:0] trig_pulse;
  logic [NA-1:0] trig_ok;
  logic [NA-1:0] host_sel;
  logic [NA-1:0] host_exec;
  logic [NA-1:0] host_clr;
  logic [NA-1:0] exec;
  logic [NA-1:0] ex_halt;
  logic [NA-1:0] ex_dir;
  logic [NA-1:0] ex_step;
  logic rom_err_q;
  logic batt_err_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic addr_ok;
  logic take_addr;
  logic wr_now;
  logic cmd_wr;
  logic [3:0] cmd_axis;
  logic [3:0] axis_base;
  logic [3:0] axis_off;
  logic [2:0] cmd_func;

  // one trigger edge detector per axis
  for (genvar g = 0; g < NA; g++)
  begin : g_trig
    trig_if tif ();
    assign tif.raw = i_trigger[g];
    assign trig_pulse[g] = tif.pulse;
    fall_detect #(.STAGES(SYNC_STAGES)) u_fall (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .port(tif)
    );
  end

  // bus address phase capture
  assign take_addr = i_hsel & i_htrans[1] & i_hready & i_ce;
  assign addr_ok = (i_haddr[31:8] == 24'h000000);
  assign wr_now = wr_pend_q & i_ce;
  assign o_hreadyout = i_ce;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_q;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else if (i_ce)
    begin
      wr_pend_q <= take_addr & i_hwrite & addr_ok;
      rd_pend_q <= take_addr & ~i_hwrite;
      wr_addr_q <= i_haddr[7:0];
    end
  end

  // read mux, registered for the data phase
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (!addr_ok)
      rdata_d = 32'h00000000;
    else if (i_haddr[7:0] == ADR_CTRL)
      rdata_d[7:0] = ctrl_q;
    else if (i_haddr[7:0] == ADR_GSTAT)
    begin
      rdata_d[GSTAT_ROM_BIT] = rom_err_q;
      rdata_d[GSTAT_BATT_BIT] = batt_err_q;
    end
    else if (i_haddr[3:2] < 2'(NA) && i_haddr[1:0] == 2'b00)
    begin
      for (int a = 0; a < NA; a++)
      begin
        if (i_haddr[3:2] == 2'(a))
        begin
          if (i_haddr[7:4] == ADR_STEP_HI)
            rdata_d[POS_W-1:0] = step_q[a];
          else if (i_haddr[7:4] == ADR_POS_HI)
            rdata_d[POS_W-1:0] = pos_q[a];
          else if (i_haddr[7:4] == ADR_TGT_HI)
            rdata_d[POS_W-1:0] = tgt_q[a];
          else if (i_haddr[7:4] == ADR_STAT_HI)
          begin
            rdata_d[STAT_POSERR_BIT] = pos_err_q[a];
            rdata_d[STAT_FWDLIM_BIT] = i_fwd_limit[a];
            rdata_d[STAT_REVLIM_BIT] = i_rev_limit[a];
            rdata_d[STAT_READY_BIT] = (state_q[a] == ST_HOLD) && (pos_q[a] == tgt_q[a]);
            rdata_d[STAT_STALL_BIT] = stall_err_q[a];
            rdata_d[STAT_STATE_LSB +: 2] = state_q[a];
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_q <= 32'h00000000;
    else if (take_addr & ~i_hwrite)
      rdata_q <= rdata_d;
  end

  // transceiver direction: high while the device drives read data
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_out_ctrl <= 1'b0;
    else if (i_ce)
      o_out_ctrl <= take_addr & ~i_hwrite;
  end

  // control and step size registers
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl_q <= CTRL_RESET;
      for (int a = 0; a < NA; a++)
        step_q[a] <= STEP_RESET;
    end
    else if (wr_now)
    begin
      if (wr_addr_q == ADR_CTRL)
        ctrl_q <= i_hwdata[7:0];
      for (int a = 0; a < NA; a++)
        if (wr_addr_q[7:4] == ADR_STEP_HI && wr_addr_q[3:0] == 4'(4 * a))
          step_q[a] <= i_hwdata[POS_W-1:0];
    end
  end

  // host command decode, axis numbers base..base+2 of 1..15
  assign cmd_wr = wr_now && (wr_addr_q == ADR_CMD);
  assign cmd_axis = i_hwdata[CMD_AXIS_LSB +: 4];
  assign cmd_func = i_hwdata[CMD_FUNC_LSB +: 3];
  assign axis_base = ctrl_q[CTRL_BASE_LSB +: 4];
  assign axis_off = cmd_axis - axis_base;
  always_comb
  begin
    for (int a = 0; a < NA; a++)
    begin
      host_sel[a] = cmd_wr && (cmd_axis != 4'h0) && (cmd_axis <= MAX_AXIS_ADDR)
        && (cmd_axis >= axis_base) && (axis_off == 4'(a));
      host_exec[a] = host_sel[a] && (cmd_func == FUNC_EXEC);
      host_clr[a] = host_sel[a] && (cmd_func == FUNC_CLR);
    end
  end

  // command source: qualified pin trigger, else host code 0
  always_comb
  begin
    for (int a = 0; a < NA; a++)
    begin
      trig_ok[a] = trig_pulse[a] & ~i_port_off & ~sup_n_q[a] & i_ce;
      exec[a] = trig_ok[a] | host_exec[a];
      ex_halt[a] = trig_ok[a] ? i_halt[a] : i_hwdata[CMD_HALT_BIT];
      ex_dir[a] = trig_ok[a] ? i_dir_fwd[a] : i_hwdata[CMD_DIR_BIT];
      ex_step[a] = trig_ok[a] ? i_step_mode[a] : i_hwdata[CMD_STEP_BIT];
      delta[a] = ex_dir[a] ? step_q[a] : POS_W'(-step_q[a]);
      base[a] = (state_q[a] == ST_SEEK) ? tgt_q[a] : pos_q[a];
    end
  end

  // supervisor present, active low
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      sup_n_q <= '1;
    else if (i_ce)
      sup_n_q <= {NA{~ctrl_q[CTRL_SUP_BIT]}};
  end
  assign o_supervisor_present_short_n = sup_n_q;

  // shaft position counters
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      for (int a = 0; a < NA; a++)
        pos_q[a] <= '0;
    else if (i_ce)
      for (int a = 0; a < NA; a++)
        if (host_clr[a])
          pos_q[a] <= '0;
        else if (i_enc_inc[a] & ~i_enc_dec[a])
          pos_q[a] <= pos_q[a] + POS_W'(1);
        else if (i_enc_dec[a] & ~i_enc_inc[a])
          pos_q[a] <= pos_q[a] - POS_W'(1);
  end

  // axis mode and target
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      run_fwd_q <= '0;
      for (int a = 0; a < NA; a++)
      begin
        state_q[a] <= ST_HOLD;
        tgt_q[a] <= '0;
      end
    end
    else if (i_ce)
    begin
      for (int a = 0; a < NA; a++)
      begin
        if (host_clr[a])
        begin
          state_q[a] <= ST_HOLD;
          tgt_q[a] <= '0;
        end
        else if (i_stall_evt[a])
        begin
          state_q[a] <= ST_HOLD;
          tgt_q[a] <= pos_q[a];
        end
        else if (exec[a] && ex_halt[a])
        begin
          state_q[a] <= ST_HOLD;
          tgt_q[a] <= pos_q[a];
        end
        else if (exec[a] && ex_step[a])
        begin
          state_q[a] <= ST_SEEK;
          tgt_q[a] <= base[a] + delta[a];
        end
        else if (exec[a])
        begin
          state_q[a] <= ST_RUN;
          run_fwd_q[a] <= ex_dir[a];
          tgt_q[a] <= pos_q[a];
        end
        else
        begin
          case (state_q[a])
            ST_RUN: tgt_q[a] <= pos_q[a];
            ST_SEEK: if (pos_q[a] == tgt_q[a]) state_q[a] <= ST_HOLD;
            default: state_q[a] <= state_q[a];
          endcase
        end
      end
    end
  end

  // drive request; a limit blocks motion but keeps the target
  always_comb
  begin
    for (int a = 0; a < NA; a++)
    begin
      fwd_d[a] = $signed(tgt_q[a]) > $signed(pos_q[a]);
      en_d[a] = 1'b0;
      case (state_q[a])
        ST_RUN:
        begin
          en_d[a] = 1'b1;
          fwd_d[a] = run_fwd_q[a];
        end
        ST_SEEK: en_d[a] = pos_q[a] != tgt_q[a];
        default: en_d[a] = ctrl_q[CTRL_MAINT_BIT] && (pos_q[a] != tgt_q[a]);
      endcase
      if ((fwd_d[a] & i_fwd_limit[a]) | (~fwd_d[a] & i_rev_limit[a]))
        en_d[a] = 1'b0;
      if (stall_err_q[a])
        en_d[a] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      drive_en_q <= '0;
      drive_fwd_q <= '0;
      drive_clk_q <= '0;
    end
    else if (i_ce)
    begin
      drive_en_q <= en_d;
      drive_fwd_q <= fwd_d;
      drive_clk_q <= en_d & i_speed_clk;
    end
  end
  assign o_drive_en = drive_en_q;
  assign o_drive_fwd = drive_fwd_q;
  assign o_drive_clk = drive_clk_q;

  // axis error flags, set wins over clear
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pos_err_q <= '0;
      stall_err_q <= '0;
    end
    else if (i_ce)
    begin
      for (int a = 0; a < NA; a++)
      begin
        if (i_pos_err_evt[a])
          pos_err_q[a] <= 1'b1;
        else if (host_clr[a])
          pos_err_q[a] <= 1'b0;
        if (i_stall_evt[a])
          stall_err_q[a] <= 1'b1;
        else if (host_clr[a] | exec[a])
          stall_err_q[a] <= 1'b0;
      end
    end
  end

  // persistent memory errors, cleared only by reset
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rom_err_q <= 1'b0;
      batt_err_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_sum_fail)
        rom_err_q <= 1'b1;
      if (i_low_batt)
        batt_err_q <= 1'b1;
    end
  end
  assign o_rom_err = rom_err_q;
  assign o_batt_err = batt_err_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  AST_RUN_START: assert property (exec[0] && !ex_halt[0] && !ex_step[0] && ex_dir[0]
    && !host_clr[0] && !i_stall_evt[0] |=> state_q[0] == ST_RUN && run_fwd_q[0])
    else $error("run trigger did not start forward run");
  AST_HALT_HOLD: assert property (exec[0] && ex_halt[0] && !host_clr[0]
    && !i_stall_evt[0] |=> state_q[0] == ST_HOLD && tgt_q[0] == $past(pos_q[0]))
    else $error("halt did not hold present position");
  AST_STEP_NEW: assert property (exec[0] && !ex_halt[0] && ex_step[0]
    && state_q[0] != ST_SEEK && !host_clr[0] && !i_stall_evt[0]
    |=> state_q[0] == ST_SEEK && tgt_q[0] == $past(pos_q[0]) + $past(delta[0]))
    else $error("step target not position plus step");
  AST_STEP_ACC: assert property (exec[0] && !ex_halt[0] && ex_step[0]
    && state_q[0] == ST_SEEK && !host_clr[0] && !i_stall_evt[0]
    |=> tgt_q[0] == $past(tgt_q[0]) + $past(delta[0]))
    else $error("step did not accumulate");
  AST_STEP_DIR: assert property (exec[0] && !ex_halt[0] && ex_step[0] && !ex_dir[0]
    && !host_clr[0] && !i_stall_evt[0]
    |=> tgt_q[0] == $past(base[0]) - $past(step_q[0]))
    else $error("reverse step not subtracted");
  AST_POSERR_STICKY: assert property (pos_err_q[0] && !host_clr[0] |=> pos_err_q[0])
    else $error("position error dropped without counter reset");
  AST_STALL_DRIVE: assert property (i_stall_evt[0] |=> stall_err_q[0] ##1 !o_drive_en[0])
    else $error("stall did not remove drive");
  AST_MEM_ERR: assert property (i_low_batt || batt_err_q |=> batt_err_q[*2])
    else $error("battery error not persistent");
  AST_ROM_ERR: assert property (i_sum_fail |=> rom_err_q ##1 rom_err_q)
    else $error("checksum error not persistent");
  AST_CLR_ZERO: assert property (host_clr[0] |=> pos_q[0] == '0 && tgt_q[0] == '0)
    else $error("counter reset left nonzero");
  AST_IGNORE: assert property (trig_pulse[0]
    && (i_port_off || o_supervisor_present_short_n[0])
    && !host_sel[0] && !i_stall_evt[0] && state_q[0] != ST_SEEK
    |=> state_q[0] == $past(state_q[0]))
    else $error("trigger accepted while port off");
  AST_OUT_CTRL: assert property (take_addr && !i_hwrite |=> o_out_ctrl)
    else $error("output control not raised for read");

  COV_RUN: cover property (trig_ok[0] && !ex_halt[0] && !ex_step[0]);
  COV_ACC: cover property (exec[0] && ex_step[0] && state_q[0] == ST_SEEK);
  COV_MIDHALT: cover property (exec[0] && ex_halt[0] && state_q[0] == ST_SEEK);
  COV_CLR: cover property (host_clr[0]);
endmodule : closed_loop_axis_trigger_control

// File: axis_ctl_pkg.sv
package axis_ctl_pkg;
  // geometry
  localparam int NUM_AXES = 3;
  localparam int POS_W = 24;
  localparam int SYNC_STAGES = 2;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CMD = 8'h04;
  localparam logic [7:0] ADR_GSTAT = 8'h08;
  localparam logic [3:0] ADR_STEP_HI = 4'h1;
  localparam logic [3:0] ADR_POS_HI = 4'h2;
  localparam logic [3:0] ADR_TGT_HI = 4'h3;
  localparam logic [3:0] ADR_STAT_HI = 4'h4;
  // control register fields and reset value
  localparam int CTRL_SUP_BIT = 0;
  localparam int CTRL_MAINT_BIT = 1;
  localparam int CTRL_BASE_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h13;
  // command register fields
  localparam int CMD_AXIS_LSB = 0;
  localparam int CMD_FUNC_LSB = 4;
  localparam int CMD_DIR_BIT = 8;
  localparam int CMD_HALT_BIT = 9;
  localparam int CMD_STEP_BIT = 10;
  localparam logic [2:0] FUNC_EXEC = 3'h0;
  localparam logic [2:0] FUNC_CLR = 3'h1;
  // axis status fields
  localparam int STAT_POSERR_BIT = 0;
  localparam int STAT_FWDLIM_BIT = 1;
  localparam int STAT_REVLIM_BIT = 2;
  localparam int STAT_READY_BIT = 3;
  localparam int STAT_STALL_BIT = 7;
  localparam int STAT_STATE_LSB = 8;
  // global status fields
  localparam int GSTAT_ROM_BIT = 0;
  localparam int GSTAT_BATT_BIT = 1;
  // step reset value, highest axis number, axis states
  localparam logic [POS_W-1:0] STEP_RESET = 24'h000001;
  localparam logic [3:0] MAX_AXIS_ADDR = 4'hF;
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_RUN = 2'b01,
    ST_SEEK = 2'b10
  } axis_state_t;
endpackage : axis_ctl_pkg

// File: trig_if.sv
`timescale 1ns/1ns
interface trig_if;
  logic raw;
  logic pulse;
  modport det (input raw, output pulse);
  modport src (output raw, input pulse);
endinterface : trig_if

// File: fall_detect.sv
`timescale 1ns/1ns
module fall_detect
#(
  parameter int STAGES = axis_ctl_pkg::SYNC_STAGES
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  trig_if.det port
);
  import axis_ctl_pkg::*;

  logic [STAGES:0] sync_q;

  // synchroniser plus one history stage, idle level high
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      sync_q <= '1;
    else if (i_ce)
      sync_q <= {sync_q[STAGES-1:0], port.raw};
  end

  // high-to-low only gives a one-cycle pulse
  assign port.pulse = sync_q[STAGES] & ~sync_q[STAGES-1];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  AST_FALL_PULSE: assert property (port.pulse |-> $past(port.raw, 3) && !$past(port.raw, 2))
    else $error("pulse without a falling edge");
  AST_PULSE_ONE: assert property (port.pulse |=> !port.pulse)
    else $error("trigger pulse longer than one cycle");
endmodule : fall_detect

// File: axis_far_end.sv
`timescale 1ns/1ns
module axis_far_end
(
  input wire logic i_clk,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_sup_n,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_drive_en,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_drive_fwd,
  input wire logic [axis_ctl_pkg::NUM_AXES-1:0] i_drive_clk,
  output logic [axis_ctl_pkg::NUM_AXES-1:0] o_trigger,
  output logic [axis_ctl_pkg::NUM_AXES-1:0] o_step_mode,
  output logic [axis_ctl_pkg::NUM_AXES-1:0] o_dir_fwd,
  output logic [axis_ctl_pkg::NUM_AXES-1:0] o_halt,
  output logic [axis_ctl_pkg::NUM_AXES-1:0] o_speed_clk,
  output logic [axis_ctl_pkg::NUM_AXES-1:0] o_enc_inc,
  output logic [axis_ctl_pkg::NUM_AXES-1:0] o_enc_dec
);
  import axis_ctl_pkg::*;
  logic spd_on;
  logic [NUM_AXES-1:0] clk_last_q;
  // idle levels: triggers high, speed clock parked low
  initial
  begin
    o_trigger = '1;
    o_step_mode = '0;
    o_dir_fwd = '0;
    o_halt = '1;
    o_speed_clk = '0;
    o_enc_inc = '0;
    o_enc_dec = '0;
    clk_last_q = '0;
    spd_on = 1'b0;
  end
  // speed clock toggles only while enabled
  always @(posedge i_clk)
    o_speed_clk <= spd_on ? ~o_speed_clk : '0;
  // encoder gives one count per drive clock rise, in drive direction
  always @(posedge i_clk)
  begin
    clk_last_q <= i_drive_clk;
    o_enc_inc <= i_drive_en & i_drive_clk & ~clk_last_q & i_drive_fwd;
    o_enc_dec <= i_drive_en & i_drive_clk & ~clk_last_q & ~i_drive_fwd;
  end
  // one command: levels settle first, then a short low pulse
  task automatic fire(input int a, input logic st, input logic dr, input logic hl,
                      input logic need_sup);
    int n;
    n = 0;
    while (need_sup && i_sup_n[a] !== 1'b0 && n < 100)
    begin
      @(posedge i_clk);
      n++;
    end
    o_step_mode[a] <= st;
    o_dir_fwd[a] <= dr;
    o_halt[a] <= hl;
    @(posedge i_clk);
    o_trigger[a] <= 1'b0;
    repeat (3) @(posedge i_clk);
    o_trigger[a] <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask : fire
endmodule : axis_far_end

// File: closed_loop_axis_trigger_control_tb.sv
`timescale 1ns/1ns
module closed_loop_axis_trigger_control_tb;
  import axis_ctl_pkg::*;
  localparam int N = NUM_AXES;
  logic i_clk, i_nrst, hsel, hwrite, hrdyo, hresp, port_off, low_batt, sum_fail;
  logic out_ctrl, rom_err, batt_err, ce;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [N-1:0] trig, stepm, dirf, halt, spd, inc, dec, fwdl, revl, perr, stall;
  logic [N-1:0] sup_n, den, dfwd, dclk;
  int n_mismatch, n_tests, cyc, n_inc;

  closed_loop_axis_trigger_control dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdyo), .o_hrdata(hrdata),
    .o_hreadyout(hrdyo), .o_hresp(hresp), .i_port_off(port_off), .i_trigger(trig),
    .i_step_mode(stepm), .i_dir_fwd(dirf), .i_halt(halt), .i_speed_clk(spd),
    .i_enc_inc(inc), .i_enc_dec(dec), .i_fwd_limit(fwdl), .i_rev_limit(revl),
    .i_pos_err_evt(perr), .i_stall_evt(stall), .i_low_batt(low_batt),
    .i_sum_fail(sum_fail), .o_supervisor_present_short_n(sup_n), .o_drive_en(den),
    .o_drive_fwd(dfwd), .o_drive_clk(dclk), .o_out_ctrl(out_ctrl),
    .o_rom_err(rom_err), .o_batt_err(batt_err));

  axis_far_end far_u (.i_clk(i_clk), .i_sup_n(sup_n), .i_drive_en(den),
    .i_drive_fwd(dfwd), .i_drive_clk(dclk), .o_trigger(trig), .o_step_mode(stepm),
    .o_dir_fwd(dirf), .o_halt(halt), .o_speed_clk(spd), .o_enc_inc(inc),
    .o_enc_dec(dec));

  // free-running clock, 40 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // hang guard
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  // encoder counts seen by the far end, axis 0
  always @(posedge i_clk)
    if (inc[0] === 1'b1)
      n_inc++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge i_clk);
    while (hrdyo !== 1'b1) @(posedge i_clk);
    htrans <= 2'b00;
    hwdata <= wd;
    #1;
    if (!w) chk({31'h0, out_ctrl}, 32'h1);
    @(posedge i_clk);
    while (hrdyo !== 1'b1) @(posedge i_clk);
    rv = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  // read and compare the masked value
  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rv & m, e);
  endtask : rdc

  initial
  begin
    i_nrst = 1'b0;
    hsel = 1'b0;
    ce = 1'b1;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    port_off = 1'b0;
    low_batt = 1'b0;
    sum_fail = 1'b0;
    fwdl = '0;
    revl = '0;
    perr = '0;
    stall = '0;
    n_mismatch = 0;
    n_tests = 0;
    cyc = 0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_clk);
    // reset values and unmapped places
    chk({29'h0, sup_n}, 32'h0);
    rdc(32'h00, 32'hFF, 32'h13);
    rdc(32'h10, 32'hFFFFFFFF, 32'h1);
    rdc(32'h08, 32'h3, 32'h0);
    rdc(32'h0C, 32'hFFFFFFFF, 32'h0);
    rdc(32'h04, 32'hFFFFFFFF, 32'h0);
    rdc(32'h100, 32'hFFFFFFFF, 32'h0);
    wr(32'h10, 32'h5);
    rdc(32'h10, 32'hFFFFFFFF, 32'h5);
    // step mode: accumulate, direction, halt mid-step
    far_u.fire(0, 1'b1, 1'b1, 1'b0, 1'b1);
    rdc(32'h30, 32'hFFFFFF, 32'h5);
    rdc(32'h40, 32'h300, 32'h200);
    far_u.fire(0, 1'b1, 1'b1, 1'b0, 1'b1);
    rdc(32'h30, 32'hFFFFFF, 32'hA);
    far_u.fire(0, 1'b1, 1'b0, 1'b0, 1'b1);
    rdc(32'h30, 32'hFFFFFF, 32'h5);
    far_u.fire(0, 1'b1, 1'b1, 1'b1, 1'b1);
    rdc(32'h40, 32'h300, 32'h0);
    rdc(32'h30, 32'hFFFFFF, 32'h0);
    far_u.fire(0, 1'b1, 1'b1, 1'b0, 1'b1);
    rdc(32'h30, 32'hFFFFFF, 32'h5);
    // step against a limit still adds up
    fwdl <= 3'b001;
    far_u.fire(0, 1'b1, 1'b1, 1'b0, 1'b1);
    rdc(32'h30, 32'hFFFFFF, 32'hA);
    rdc(32'h40, 32'h302, 32'h202);
    fwdl <= 3'b000;
    far_u.fire(0, 1'b1, 1'b1, 1'b1, 1'b1);
    // plain run then halt
    far_u.fire(0, 1'b0, 1'b1, 1'b0, 1'b1);
    rdc(32'h40, 32'h300, 32'h100);
    chk({30'h0, den[0], dfwd[0]}, 32'h3);
    far_u.spd_on <= 1'b1;
    repeat (40) @(posedge i_clk);
    far_u.spd_on <= 1'b0;
    repeat (4) @(posedge i_clk);
    rdc(32'h20, 32'hFFFFFF, 32'(n_inc));
    chk({31'h0, rv[23:0] != 24'h0}, 32'h1);
    far_u.fire(0, 1'b0, 1'b1, 1'b1, 1'b1);
    rdc(32'h40, 32'h300, 32'h0);
    // clock enable low freezes the detector, trigger lost
    ce <= 1'b0;
    far_u.fire(0, 1'b0, 1'b1, 1'b0, 1'b1);
    ce <= 1'b1;
    rdc(32'h40, 32'h300, 32'h0);
    // ignored triggers: port off, then supervisor withdrawn
    port_off <= 1'b1;
    far_u.fire(0, 1'b0, 1'b1, 1'b0, 1'b1);
    rdc(32'h40, 32'h300, 32'h0);
    port_off <= 1'b0;
    wr(32'h00, 32'h12);
    repeat (2) @(posedge i_clk);
    chk({31'h0, sup_n[0]}, 32'h1);
    far_u.fire(0, 1'b0, 1'b1, 1'b0, 1'b0);
    rdc(32'h40, 32'h300, 32'h0);
    wr(32'h00, 32'h13);
    // host commands, other axes, out-of-range axis number
    wr(32'h04, 32'h105);
    rdc(32'h48, 32'h300, 32'h0);
    wr(32'h04, 32'h103);
    rdc(32'h48, 32'h300, 32'h100);
    far_u.fire(2, 1'b0, 1'b1, 1'b1, 1'b1);
    rdc(32'h48, 32'h300, 32'h0);
    wr(32'h04, 32'h101);
    rdc(32'h40, 32'h300, 32'h100);
    // error flags
    @(posedge i_clk);
    perr <= 3'b001;
    stall <= 3'b001;
    low_batt <= 1'b1;
    sum_fail <= 1'b1;
    @(posedge i_clk);
    perr <= 3'b000;
    stall <= 3'b000;
    low_batt <= 1'b0;
    sum_fail <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk({31'h0, den[0]}, 32'h0);
    rdc(32'h40, 32'h381, 32'h81);
    chk({30'h0, batt_err, rom_err}, 32'h3);
    rdc(32'h08, 32'h3, 32'h3);
    wr(32'h04, 32'h201);
    rdc(32'h40, 32'h81, 32'h1);
    rdc(32'h08, 32'h3, 32'h3);
    wr(32'h04, 32'h011);
    rdc(32'h20, 32'hFFFFFF, 32'h0);
    rdc(32'h30, 32'hFFFFFF, 32'h0);
    rdc(32'h40, 32'h81, 32'h0);
    close_out();
  end
endmodule : closed_loop_axis_trigger_control_tb
